// ===== hw/tlf_ctrl.sv
// Purpose: Control and status registers of the time control loop
// Assumes: Network side and local side both byte-wide, same clock, rdata one cycle after rd
// Notes:   Filter engine outside supplies averaged difference and raw deviation
`timescale 1ns/1ps

module tlf_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        local_owns_time,
  input  wire logic        net_wr,
  input  wire logic        net_rd,
  input  wire logic [11:0] net_addr,
  input  wire logic [7:0]  net_wdata,
  output logic      [7:0]  net_rdata,
  input  wire logic        loc_wr,
  input  wire logic        loc_rd,
  input  wire logic [11:0] loc_addr,
  input  wire logic [7:0]  loc_wdata,
  output logic      [7:0]  loc_rdata,
  input  wire logic        diff_upd,
  input  wire logic [30:0] diff_mag,
  input  wire logic        diff_local_below,
  input  wire logic        dev_upd,
  input  wire logic [15:0] dev_raw,
  input  wire logic        latch_write_evt,
  output logic      [31:0] propagation_delay,
  output logic      [14:0] adjust_bandwidth,
  output logic      [3:0]  difference_filter_depth,
  output logic      [3:0]  deviation_filter_depth,
  output logic             diff_filter_clear,
  output logic             dev_filter_clear,
  output logic             stamp_arm,
  output logic             stamp_take_hidden
);

  tlf_pkg::tlf_state_t s_q;
  tlf_pkg::tlf_state_t s_d;
  logic [23:0]         held_upper [tlf_pkg::SIDES];
  logic                side_wr    [tlf_pkg::SIDES];
  logic                side_rd    [tlf_pkg::SIDES];
  logic [11:0]         side_addr  [tlf_pkg::SIDES];
  logic [7:0]          side_wdata [tlf_pkg::SIDES];
  logic [7:0]          side_rbyte [tlf_pkg::SIDES];

  // ************************************************************
  // Helpers
  // ************************************************************
  // Limit a raw deviation to plus or minus (start - margin)
  function automatic logic [15:0] clamp_dev(input logic [15:0] raw, input logic [14:0] bw);
    logic signed [16:0] lim;
    logic signed [16:0] val;
    lim = $signed({2'b00, bw}) - $signed({1'b0, tlf_pkg::DEV_MARGIN});
    val = $signed({raw[15], raw});
    if (val > lim) begin
      clamp_dev = lim[15:0];
    end else if (val < -lim) begin
      clamp_dev = 16'(-lim);
    end else begin
      clamp_dev = raw;
    end
  endfunction

  // Read one byte of the map; difference upper bytes come from the side's holding copy
  function automatic logic [7:0] read_byte(input logic [11:0] a, input tlf_pkg::tlf_state_t s,
                                           input logic [23:0] held);
    logic [31:0] dword;
    dword = {held, s.diff[7:0]};
    if (a[11:2] == tlf_pkg::ADDR_WORD_DELAY) begin
      read_byte = s.delay[8*a[1:0] +: 8];
    end else if (a[11:2] == tlf_pkg::ADDR_WORD_DIFF) begin
      read_byte = dword[8*a[1:0] +: 8];
    end else if (a == tlf_pkg::ADDR_BW) begin
      read_byte = s.bw[7:0];
    end else if (a == tlf_pkg::ADDR_BW_HI) begin
      read_byte = {1'b0, s.bw[14:8]};
    end else if (a == tlf_pkg::ADDR_DEV) begin
      read_byte = s.dev[7:0];
    end else if (a == tlf_pkg::ADDR_DEV_HI) begin
      read_byte = s.dev[15:8];
    end else if (a == tlf_pkg::ADDR_DDEPTH) begin
      read_byte = {4'h0, s.ddepth};
    end else if (a == tlf_pkg::ADDR_VDEPTH) begin
      read_byte = {4'h0, s.vdepth};
    end else if (a == tlf_pkg::ADDR_LMODE) begin
      read_byte = {7'h00, s.lmode};
    end else begin
      read_byte = tlf_pkg::BYTE_ZERO;
    end
  endfunction

  // ************************************************************
  // Access sides
  // ************************************************************
  // Gather both sides into arrays; local side writes only when it owns time
  always_comb begin
    side_wr[tlf_pkg::SIDE_LOC]    = loc_wr && local_owns_time;
    side_rd[tlf_pkg::SIDE_LOC]    = loc_rd;
    side_addr[tlf_pkg::SIDE_LOC]  = loc_addr;
    side_wdata[tlf_pkg::SIDE_LOC] = loc_wdata;
    side_wr[tlf_pkg::SIDE_NET]    = net_wr;
    side_rd[tlf_pkg::SIDE_NET]    = net_rd;
    side_addr[tlf_pkg::SIDE_NET]  = net_addr;
    side_wdata[tlf_pkg::SIDE_NET] = net_wdata;
  end

  // Holding copy and read byte per side
  for (genvar g = 0; g < tlf_pkg::SIDES; g++) begin : g_side
    tlf_hold u_hold (
      .clk        (clk),
      .rstn       (rstn),
      .rd         (side_rd[g]),
      .addr       (side_addr[g]),
      .diff_live  (s_q.diff),
      .held_upper (held_upper[g])
    );
    assign side_rbyte[g] = read_byte(side_addr[g], s_q, held_upper[g]);
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Engine updates first, then local writes, then network writes so network wins
  always_comb begin
    s_d              = s_q;
    s_d.clr_diff_flt = 1'b0;
    s_d.clr_dev_flt  = 1'b0;
    s_d.arm          = 1'b0;
    s_d.take         = 1'b0;
    if (diff_upd) begin
      s_d.diff = {diff_local_below, diff_mag};
    end
    if (dev_upd) begin
      s_d.dev = clamp_dev(dev_raw, s_q.bw);
    end
    for (int i = 0; i < tlf_pkg::SIDES; i++) begin
      if (side_wr[i]) begin
        if (side_addr[i][11:2] == tlf_pkg::ADDR_WORD_DELAY) begin
          s_d.delay[8*side_addr[i][1:0] +: 8] = side_wdata[i];
        end else if (side_addr[i] == tlf_pkg::ADDR_BW || side_addr[i] == tlf_pkg::ADDR_BW_HI) begin
          if (side_addr[i] == tlf_pkg::ADDR_BW) begin
            s_d.bw[7:0] = side_wdata[i];
          end else begin
            s_d.bw[14:8] = side_wdata[i][6:0];
          end
          s_d.diff         = tlf_pkg::RST_DIFF;
          s_d.dev          = tlf_pkg::RST_DEV;
          s_d.clr_diff_flt = 1'b1;
          s_d.clr_dev_flt  = 1'b1;
        end else if (side_addr[i] == tlf_pkg::ADDR_DDEPTH) begin
          s_d.ddepth       = side_wdata[i][3:0];
          s_d.diff         = tlf_pkg::RST_DIFF;
          s_d.clr_diff_flt = 1'b1;
        end else if (side_addr[i] == tlf_pkg::ADDR_VDEPTH) begin
          s_d.vdepth      = side_wdata[i][3:0];
          s_d.clr_dev_flt = 1'b1;
        end else if (side_addr[i] == tlf_pkg::ADDR_LMODE && i == tlf_pkg::SIDE_NET) begin
          s_d.lmode = side_wdata[i][0];
        end
      end
    end
    if (latch_write_evt) begin
      s_d.arm  = !s_q.lmode;
      s_d.take = s_q.lmode;
    end
    s_d.net_rdata = net_rd ? side_rbyte[tlf_pkg::SIDE_NET] : tlf_pkg::BYTE_ZERO;
    s_d.loc_rdata = loc_rd ? side_rbyte[tlf_pkg::SIDE_LOC] : tlf_pkg::BYTE_ZERO;
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q        <= '0;
      s_q.delay  <= tlf_pkg::RST_DELAY;
      s_q.diff   <= tlf_pkg::RST_DIFF;
      s_q.bw     <= tlf_pkg::RST_BW;
      s_q.dev    <= tlf_pkg::RST_DEV;
      s_q.ddepth <= tlf_pkg::RST_DDEPTH;
      s_q.vdepth <= tlf_pkg::RST_VDEPTH;
      s_q.lmode  <= tlf_pkg::RST_LMODE;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign propagation_delay       = s_q.delay;
  assign adjust_bandwidth        = s_q.bw;
  assign difference_filter_depth = s_q.ddepth;
  assign deviation_filter_depth  = s_q.vdepth;
  assign diff_filter_clear       = s_q.clr_diff_flt;
  assign dev_filter_clear        = s_q.clr_dev_flt;
  assign stamp_arm               = s_q.arm;
  assign stamp_take_hidden       = s_q.take;
  assign net_rdata               = s_q.net_rdata;
  assign loc_rdata               = s_q.loc_rdata;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_BW_CLEARS: assert property (
    (net_wr && (net_addr == tlf_pkg::ADDR_BW || net_addr == tlf_pkg::ADDR_BW_HI))
      |=> s_q.diff == '0 && s_q.dev == '0 && diff_filter_clear
      && dev_filter_clear)
    else $error("start write did not clear difference and deviation");

  AST_LOC_BLOCKED: assert property (
    (loc_wr && !local_owns_time && !net_wr) |=> $stable(propagation_delay) && $stable(adjust_bandwidth)
      && $stable(difference_filter_depth) && $stable(deviation_filter_depth))
    else $error("local side wrote loop registers without owning time");

  AST_LOC_ALLOWED: assert property (
    (loc_wr && local_owns_time && !net_wr && loc_addr == tlf_pkg::ADDR_DDEPTH)
      |=> difference_filter_depth == $past(loc_wdata[3:0]))
    else $error("owning local side could not write the depth");

  AST_LMODE_NET_ONLY: assert property (
    (!(net_wr && net_addr == tlf_pkg::ADDR_LMODE)) |=> $stable(s_q.lmode))
    else $error("latch mode changed without a network write");

  AST_DEV_RANGE: assert property (
    (dev_upd && !net_wr && !loc_wr) |=> ($signed(s_q.dev) <= $signed({1'b0, adjust_bandwidth}) - 16'sh007F)
      && ($signed(s_q.dev) >= 16'sh007F - $signed({1'b0, adjust_bandwidth})))
    else $error("deviation outside its limit");

  AST_DIFF_SIGN: assert property (
    (diff_upd && !net_wr && !loc_wr) |=> s_q.diff[31] == $past(diff_local_below)
      && s_q.diff[30:0] == $past(diff_mag))
    else $error("difference register not loaded from the filter");

  AST_DDEPTH_CLEAR: assert property (
    ((net_wr && net_addr == tlf_pkg::ADDR_DDEPTH) || (loc_wr && local_owns_time && loc_addr == tlf_pkg::ADDR_DDEPTH))
      |=> s_q.diff == '0 && diff_filter_clear ##1 (!diff_filter_clear || $past(net_wr || loc_wr)))
    else $error("difference depth write did not clear the difference");

  AST_VDEPTH_CLEAR: assert property (
    (net_wr && net_addr == tlf_pkg::ADDR_VDEPTH) |=> dev_filter_clear && deviation_filter_depth
      == $past(net_wdata[3:0]))
    else $error("deviation depth write did not clear the speed filter");

  AST_ARM_FWD: assert property (
    (latch_write_evt && !s_q.lmode) |=> stamp_arm && !stamp_take_hidden)
    else $error("forwarding mode did not arm stamping");

  AST_TAKE_REV: assert property (
    (latch_write_evt && s_q.lmode) |=> stamp_take_hidden && !stamp_arm)
    else $error("reverse mode did not take hidden stamps");

  AST_RD_RESERVED: assert property (
    (net_rd && net_addr == tlf_pkg::ADDR_BW_HI) |=> net_rdata[7] == 1'b0)
    else $error("reserved start bit read as one");

  COV_BW_WRITE: cover property (net_wr && net_addr == tlf_pkg::ADDR_BW ##1 diff_upd);
  COV_REVERSE: cover property (net_wr && net_addr == tlf_pkg::ADDR_LMODE && net_wdata[0] ##[1:4] latch_write_evt);
  COV_LOC_WRITE: cover property (loc_wr && local_owns_time && loc_addr == tlf_pkg::ADDR_DELAY);
  COV_DIFF_READ: cover property (net_rd && net_addr == tlf_pkg::ADDR_DIFF ##1 diff_upd ##1 net_rd);

endmodule

// ===== hw/tlf_hold.sv
// Purpose: Per-side holding copy of the upper difference bits
// Assumes: Read strobe and address from one access side, same clock
// Notes:   Captured when the lowest difference byte is read
`timescale 1ns/1ps
module tlf_hold (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        rd,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] diff_live,
  output logic      [23:0] held_upper
);

  tlf_pkg::tlf_hold_t s_q;
  tlf_pkg::tlf_hold_t s_d;

  // ************************************************************
  // Capture logic
  // ************************************************************
  // Take bits 31:8 on a low-byte read
  always_comb begin
    s_d = s_q;
    if (rd && addr == tlf_pkg::ADDR_DIFF) begin
      s_d.upper = diff_live[31:8];
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign held_upper = s_q.upper;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_HOLD_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == tlf_pkg::ADDR_DIFF) |=> held_upper == $past(diff_live[31:8]))
    else $error("holding copy did not capture upper difference bits");

  AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (!rstn)
    !(rd && addr == tlf_pkg::ADDR_DIFF) |=> $stable(held_upper))
    else $error("holding copy changed without a low-byte read");

endmodule

// ===== pkg/tlf_pkg.sv
// Purpose: Shared constants and state type of the time loop filter control block
// Assumes: Byte-wide register access from two sides, 12-bit byte addresses
// Notes:   All offsets, reset values and field widths live here
package tlf_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [11:0] ADDR_DELAY  = 12'h928;
  localparam logic [11:0] ADDR_DIFF   = 12'h92C;
  localparam logic [11:0] ADDR_BW     = 12'h930;
  localparam logic [11:0] ADDR_BW_HI  = 12'h931;
  localparam logic [11:0] ADDR_DEV    = 12'h932;
  localparam logic [11:0] ADDR_DEV_HI = 12'h933;
  localparam logic [11:0] ADDR_DDEPTH = 12'h934;
  localparam logic [11:0] ADDR_VDEPTH = 12'h935;
  localparam logic [11:0] ADDR_LMODE  = 12'h936;
  localparam logic [9:0]  ADDR_WORD_DELAY = 10'h24A;
  localparam logic [9:0]  ADDR_WORD_DIFF  = 10'h24B;

  // ************************************************************
  // Reset values and field constants
  // ************************************************************
  localparam logic [31:0] RST_DELAY  = 32'h0000_0000;
  localparam logic [31:0] RST_DIFF   = 32'h0000_0000;
  localparam logic [14:0] RST_BW     = 15'h1000;
  localparam logic [15:0] RST_DEV    = 16'h0000;
  localparam logic [3:0]  RST_DDEPTH = 4'h4;
  localparam logic [3:0]  RST_VDEPTH = 4'hC;
  localparam logic        RST_LMODE  = 1'b0;
  localparam logic [15:0] DEV_MARGIN = 16'h007F;
  localparam logic [14:0] BW_MIN     = 15'h0080;
  localparam logic [14:0] BW_MAX     = 15'h3FFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam int          SIDES      = 2;
  localparam int          SIDE_LOC   = 0;
  localparam int          SIDE_NET   = 1;

  // ************************************************************
  // Block state
  // ************************************************************
  typedef struct packed {
    logic [31:0] delay;
    logic [31:0] diff;
    logic [14:0] bw;
    logic [15:0] dev;
    logic [3:0]  ddepth;
    logic [3:0]  vdepth;
    logic        lmode;
    logic [7:0]  net_rdata;
    logic [7:0]  loc_rdata;
    logic        clr_diff_flt;
    logic        clr_dev_flt;
    logic        arm;
    logic        take;
  } tlf_state_t;

  typedef struct packed {
    logic [23:0] upper;
  } tlf_hold_t;

endpackage

// ===== tb/tb.sv
// Purpose: Self-checking bench for the time loop register block
// Assumes: Read data is valid in the cycle after the read is taken
// Notes:   Expected read bytes queue per side; a watcher pops them
`timescale 1ns/1ps
module tb;
  typedef struct {string nm; logic [7:0] v;} tlf_note_t;
  logic        clk, rstn, local_owns_time, diff_upd, diff_local_below, dev_upd, latch_write_evt;
  logic [30:0] diff_mag;
  logic [15:0] dev_raw, rs;
  logic [31:0] dv1, dv2;
  wire logic   net_wr, net_rd, loc_wr, loc_rd;
  wire logic [11:0] net_addr, loc_addr;
  wire logic [7:0]  net_wdata, loc_wdata, net_rdata, loc_rdata;
  wire logic [31:0] propagation_delay;
  wire logic [14:0] adjust_bandwidth;
  wire logic [3:0]  difference_filter_depth, deviation_filter_depth;
  wire logic   diff_filter_clear, dev_filter_clear, stamp_arm, stamp_take_hidden;
  tlf_note_t   nq0[$], nq1[$];
  logic        pend [2];
  int          err_count, tests_run, cyc;

  tlf_host_model host (.clk, .net_wr, .net_rd, .net_addr, .net_wdata, .loc_wr, .loc_rd, .loc_addr, .loc_wdata);
  tlf_ctrl uut (.clk, .rstn, .local_owns_time, .net_wr, .net_rd, .net_addr, .net_wdata, .net_rdata, .loc_wr,
    .loc_rd, .loc_addr, .loc_wdata, .loc_rdata, .diff_upd, .diff_mag, .diff_local_below, .dev_upd, .dev_raw,
    .latch_write_evt, .propagation_delay, .adjust_bandwidth, .difference_filter_depth, .deviation_filter_depth,
    .diff_filter_clear, .dev_filter_clear, .stamp_arm, .stamp_take_hidden);

  // Clock and time limit
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Compare tasks and watcher
  // ************************************************************
  task automatic chk_v(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rd(int s);
    tlf_note_t n;
    n = s ? nq1.pop_front() : nq0.pop_front();
    chk_v(n.nm, {24'h0, n.v}, {24'h0, s ? net_rdata : loc_rdata});
  endtask

  // Read data is looked at in the cycle after the read was taken
  always @(negedge clk) begin
    for (int s = 0; s < 2; s++) begin
      if (pend[s]) chk_rd(s);
    end
    pend[0] = loc_rd;
    pend[1] = net_rd;
  end

  // ************************************************************
  // Stimulus helpers
  // ************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd32(output logic [31:0] v);
    rs = lfsr_next(rs);
    v[15:0] = rs;
    rs = lfsr_next(rs);
    v[31:16] = rs;
  endtask

  task automatic wr(int s, logic [11:0] a, logic [7:0] d);
    host.acc(s, 1'b1, a, d);
  endtask

  task automatic rd(int s, logic [11:0] a, logic [7:0] e, string nm);
    tlf_note_t n;
    n.nm = nm;
    n.v = e;
    if (s) nq1.push_back(n);
    else nq0.push_back(n);
    host.acc(s, 1'b0, a, 8'h00);
  endtask

  // Filter engine update: kind 1 difference, kind 0 deviation
  task automatic eng(bit k, logic [31:0] v);
    @(posedge clk);
    if (k) begin
      diff_upd <= 1'b1;
      diff_mag <= v[30:0];
      diff_local_below <= v[31];
    end else begin
      dev_upd <= 1'b1;
      dev_raw <= v[15:0];
    end
    @(posedge clk);
    diff_upd <= 1'b0;
    dev_upd <= 1'b0;
    diff_mag <= ~v[30:0];
    dev_raw <= ~v[15:0];
  endtask

  // Clear pulses one cycle after a write, then gone
  task automatic pulses(logic ed, logic ev);
    #1;
    chk_v("diff_filter_clear", {31'h0, ed}, {31'h0, diff_filter_clear});
    chk_v("dev_filter_clear", {31'h0, ev}, {31'h0, dev_filter_clear});
    @(posedge clk);
    #1;
    chk_v("clear_pulse_end", 32'h0, {30'h0, diff_filter_clear, dev_filter_clear});
  endtask

  // Latch event and the stamp pulse of the given mode
  task automatic latch(logic m);
    @(posedge clk);
    latch_write_evt <= 1'b1;
    @(posedge clk);
    latch_write_evt <= 1'b0;
    #1;
    chk_v("stamp_pulse", {30'h0, !m, m}, {30'h0, stamp_arm, stamp_take_hidden});
    @(posedge clk);
    #1;
    chk_v("stamp_pulse_end", 32'h0, {30'h0, stamp_arm, stamp_take_hidden});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {clk, rstn, local_owns_time, diff_upd, diff_local_below, dev_upd, latch_write_evt} = 7'h00;
    {diff_mag, dev_raw, pend[0], pend[1]} = 49'h0;
    {err_count, tests_run, cyc} = '0;
    rs = 16'h003A;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Reset values of every byte and one unmapped place
    for (int i = 0; i < 16; i++) begin
      rd(1, 12'h928 + 12'(i), 8'(128'h0000_0C04_0000_1000_0000_0000_0000_0000 >> (8 * i)), "reset_byte");
    end
    chk_v("bw_port", 32'h1000, {17'h0, adjust_bandwidth});
    // Delay written, start rewritten, then delay read back
    rnd32(dv1);
    for (int i = 0; i < 4; i++) wr(1, 12'h928 + 12'(i), dv1[8*i+:8]);
    wr(1, 12'h930, 8'h00);
    pulses(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) rd(1, 12'h928 + 12'(i), dv1[8*i+:8], "delay_byte");
    chk_v("delay_port", dv1, propagation_delay);
    // Local writes refused until local side owns time
    wr(0, 12'h934, 8'h07);
    rd(1, 12'h934, 8'h04, "loc_refused");
    rnd32(dv1);
    dv1[0] = 1'b1;
    eng(1'b1, dv1);
    local_owns_time <= 1'b1;
    wr(0, 12'h934, 8'h07);
    pulses(1'b1, 1'b0);
    rd(0, 12'h934, 8'h07, "loc_accepted");
    chk_v("ddepth_port", 32'h7, {28'h0, difference_filter_depth});
    rd(0, 12'h92C, 8'h00, "diff_cleared_by_depth");
    wr(0, 12'h936, 8'h01);
    rd(0, 12'h936, 8'h00, "loc_mode_refused");
    wr(1, 12'h932, 8'hFF);
    rd(1, 12'h932, 8'h00, "dev_read_only");
    // Consistent difference read, copies kept per side
    rnd32(dv1);
    rnd32(dv2);
    eng(1'b1, dv1);
    rd(1, 12'h92C, dv1[7:0], "diff_b0");
    eng(1'b1, dv2);
    for (int i = 1; i < 4; i++) rd(1, 12'h92C + 12'(i), dv1[8*i+:8], "diff_held");
    for (int i = 0; i < 4; i++) rd(0, 12'h92C + 12'(i), dv2[8*i+:8], "diff_loc");
    // Deviation limited by the start value at its minimum
    wr(1, 12'h930, 8'h80);
    wr(1, 12'h931, 8'h00);
    eng(1'b0, 32'h7FFF);
    rd(1, 12'h932, 8'h01, "dev_pos_limit");
    eng(1'b0, 32'h8000);
    rd(1, 12'h932, 8'hFF, "dev_neg_lo");
    rd(1, 12'h933, 8'hFF, "dev_neg_hi");
    // Start write clears difference and deviation
    eng(1'b1, dv1 | 32'h1);
    wr(1, 12'h931, 8'h3F);
    pulses(1'b1, 1'b1);
    rd(1, 12'h92C, 8'h00, "diff_cleared");
    rd(1, 12'h933, 8'h00, "dev_cleared");
    chk_v("bw_port", 32'h3F80, {17'h0, adjust_bandwidth});
    // Deviation depth clears the filter, not the register
    eng(1'b0, 32'h0005);
    wr(1, 12'h935, 8'h08);
    pulses(1'b0, 1'b1);
    rd(1, 12'h932, 8'h05, "dev_kept");
    wr(1, 12'h930, 8'h80);
    chk_v("vdepth_port", 32'h8, {28'h0, deviation_filter_depth});
    // Both stamp modes
    latch(1'b0);
    wr(1, 12'h936, 8'h01);
    rd(0, 12'h936, 8'h01, "mode_read");
    latch(1'b1);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule

// ===== tb/tlf_host_model.sv
// Purpose: Host model that makes byte requests for both access sides
// Assumes: A request is set after one edge and taken at the next edge
// Notes:   Once a request is released, the data lines show the inverse of the last byte
`timescale 1ns/1ps
module tlf_host_model (
  input  wire logic        clk,
  output logic             net_wr,
  output logic             net_rd,
  output logic      [11:0] net_addr,
  output logic      [7:0]  net_wdata,
  output logic             loc_wr,
  output logic             loc_rd,
  output logic      [11:0] loc_addr,
  output logic      [7:0]  loc_wdata
);
  logic        wr [2];
  logic        rd [2];
  logic [11:0] ad [2];
  logic [7:0]  wd [2];

  // ************************************************************
  // Side 1 is network, side 0 is local
  // ************************************************************
  assign net_wr    = wr[1];
  assign net_rd    = rd[1];
  assign net_addr  = ad[1];
  assign net_wdata = wd[1];
  assign loc_wr    = wr[0];
  assign loc_rd    = rd[0];
  assign loc_addr  = ad[0];
  assign loc_wdata = wd[0];

  // Idle at time zero
  initial begin
    for (int s = 0; s < 2; s++) begin
      wr[s] = 1'b0;
      rd[s] = 1'b0;
      ad[s] = 12'h000;
      wd[s] = 8'h00;
    end
  end

  // One byte access, held up to the edge that takes it
  task automatic acc(input int s, input bit w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr[s] <= w;
    rd[s] <= !w;
    ad[s] <= a;
    wd[s] <= d;
    @(posedge clk);
    wr[s] <= 1'b0;
    rd[s] <= 1'b0;
    wd[s] <= ~d;
  endtask
endmodule
